/* hdl/nvp_core.sv */
// fuse store, fuse latching and parallel-programming command engine
// assumes programmer pins already synchronous to i_clk; memories sit outside
module nvp_core
    import nvp_pkg::*;
#(
    parameter int         BUSY_CYCLES = NVP_BUSY_CYCLES,   // length of one operation
    parameter logic [7:0] SIG_BYTE0   = 8'h5A,             // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1   = 8'h3C,             // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2   = 8'h01,             // arbitrary identity value
    parameter logic [7:0] CAL_BYTE    = 8'h80              // rc trim value
)(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // mode control
    input  wire logic               i_power_up,      // power-up pulse in normal mode
    input  wire logic               i_prog_entry,    // programming-mode entry pulse
    input  wire logic               i_prog_mode,     // level: in parallel programming
    input  wire logic               i_serial_mode,   // level: in serial programming
    // programmer pins
    input  wire nvp_pkg::nvp_pins_t i_pins,
    input  wire logic [7:0]         i_data,          // data bus input side
    output logic [7:0]              o_data,          // data bus output side
    output logic                    o_data_oe,       // high while driving data
    output logic                    o_ready_busy_n,  // low while busy
    // memory side
    output logic [7:0]              o_addr_low,
    output logic [7:0]              o_addr_high,
    output logic [6:0]              o_word_in_page_index,
    output logic [9:0]              o_page_index,
    output logic [2:0]              o_eeprom_byte_addr,
    output logic                    o_erase_flash,   // pulse: chip erase flash
    output logic                    o_erase_eeprom,  // pulse: erase eeprom too
    output logic [7:0]              o_cmd,           // loaded command
    output logic                    o_cmd_start,     // pulse: start loaded command
    // decoded configuration
    output nvp_pkg::nvp_fuse_cfg_t  o_cfg,
    output logic [7:0]              o_rc_osc_trim_reg
);
    import nvp_pkg::*;

    if (BUSY_CYCLES < 1 || BUSY_CYCLES > 16'hFFFF)
    begin : g_busy_range
        $error("BUSY_CYCLES out of range");
    end

    // ****************************************
    // state
    // ****************************************
    nvp_state_t  state, next_state;        // ready or busy
    logic [15:0] busy_cnt, next_busy_cnt;  // cycles left in operation
    logic [7:0]  cmd, next_cmd;            // last loaded command
    logic [7:0]  addr_lo, next_addr_lo;    // address low byte
    logic [7:0]  addr_hi, next_addr_hi;    // address high byte
    logic [7:0]  dat_lo, next_dat_lo;      // data low byte

    logic [7:0]  fuse_lo, next_fuse_lo;    // stored fuse bytes
    logic [7:0]  fuse_hi, next_fuse_hi;
    logic [7:0]  fuse_ext, next_fuse_ext;
    logic [7:0]  lock, next_lock;          // lock byte, 1 = unprogrammed

    logic [7:0]  lat_lo, next_lat_lo;      // latched fuse copies
    logic [7:0]  lat_hi, next_lat_hi;
    logic [7:0]  dout, next_dout;          // read data register
    logic [7:0]  trim, next_trim;          // oscillator trim

    logic        clk_q, wr_q, oe_q;        // pin history for edges
    logic        erase_f, next_erase_f;
    logic        erase_e, next_erase_e;
    logic        start, next_start;

    logic clk_rise, wr_fall, oe_fall, ready;
    assign clk_rise = i_pins.prog_clock_in & ~clk_q;
    assign wr_fall  = ~i_pins.wr_n & wr_q;
    assign oe_fall  = ~i_pins.oe_n & oe_q;
    assign ready    = (state == NVP_ST_READY);

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        next_state    = state;
        next_busy_cnt = busy_cnt;
        next_cmd      = cmd;
        next_addr_lo  = addr_lo;
        next_addr_hi  = addr_hi;
        next_dat_lo   = dat_lo;

        next_fuse_lo  = fuse_lo;
        next_fuse_hi  = fuse_hi;
        next_fuse_ext = fuse_ext;
        next_lock     = lock;
        next_lat_lo   = lat_lo;
        next_lat_hi   = lat_hi;
        next_dout     = dout;
        next_trim     = CAL_BYTE;

        next_erase_f  = 1'b0;
        next_erase_e  = 1'b0;
        next_start    = 1'b0;

        // capture only on entry or power-up
        if (i_prog_entry || i_power_up)
        begin
            next_lat_lo = fuse_lo;
            next_lat_hi = fuse_hi;
        end

        case (state)
            NVP_ST_READY:
            begin
                // clock pulse action; nothing taken while busy
                if (i_prog_mode && clk_rise)
                begin
                    case (nvp_action_t'(i_pins.action_sel))
                        NVP_ACT_ADDR:
                        begin
                            if (i_pins.byte_select_low)
                            begin
                                next_addr_hi = i_data;
                            end
                            else
                            begin
                                next_addr_lo = i_data;
                            end
                        end
                        NVP_ACT_DATA: next_dat_lo = i_data;
                        NVP_ACT_CMD:  next_cmd    = i_data;
                        default:      next_cmd    = cmd;   // idle
                    endcase
                end

                // write strobe runs loaded command
                else if (i_prog_mode && wr_fall)
                begin
                    next_state    = NVP_ST_BUSY;
                    next_busy_cnt = 16'(BUSY_CYCLES);
                    next_start    = 1'b1;
                    if (cmd == NVP_CMD_CHIP_ERASE)
                    begin
                        next_erase_f = 1'b1;
                        // fuses and user pages untouched
                        next_erase_e = fuse_hi[NVP_HI_EEKEEP];
                        next_lock    = 8'hFF;
                    end
                    else if (cmd == NVP_CMD_WR_FUSE && lock[NVP_LOCK_FIRST])
                    begin
                        case ({i_pins.byte_select_high, i_pins.byte_select_low})
                            2'b00: next_fuse_lo = dat_lo;
                            2'b01:
                            begin
                                next_fuse_hi = dat_lo;
                                if (i_serial_mode)
                                begin
                                    next_fuse_hi[NVP_HI_SERIAL] = fuse_hi[NVP_HI_SERIAL];
                                end
                            end
                            2'b10: next_fuse_ext = dat_lo;
                            default: next_fuse_ext = fuse_ext;
                        endcase
                    end
                    else if (cmd == NVP_CMD_WR_LOCK)
                    begin
                        next_lock = lock & dat_lo;
                    end
                end

                // output enable runs read commands
                else if (i_prog_mode && oe_fall)
                begin
                    if (cmd == NVP_CMD_RD_SIG)
                    begin
                        case (addr_lo[1:0])
                            2'b00:   next_dout = i_pins.byte_select_low ? CAL_BYTE : SIG_BYTE0;
                            2'b01:   next_dout = SIG_BYTE1;
                            default: next_dout = SIG_BYTE2;
                        endcase
                    end
                    else if (cmd == NVP_CMD_RD_FUSE)
                    begin
                        case ({i_pins.byte_select_high, i_pins.byte_select_low})
                            2'b00:   next_dout = fuse_lo;
                            2'b01:   next_dout = lock;
                            2'b10:   next_dout = fuse_ext;
                            default: next_dout = fuse_hi;
                        endcase
                    end
                    else
                    begin
                        next_start = 1'b1;
                    end
                end
            end

            NVP_ST_BUSY:
            begin
                // count down the operation
                if (busy_cnt <= 16'h0001)
                begin
                    next_state = NVP_ST_READY;
                end
                next_busy_cnt = busy_cnt - 16'h0001;
            end

            default: next_state = NVP_ST_READY;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state    <= NVP_ST_READY;
            busy_cnt <= 16'h0000;
            cmd      <= 8'h00;
            addr_lo  <= 8'h00;
            addr_hi  <= 8'h00;
            dat_lo   <= 8'h00;

            fuse_lo  <= NVP_FUSE_LOW_DEF;
            fuse_hi  <= NVP_FUSE_HIGH_DEF;
            fuse_ext <= NVP_FUSE_EXT_DEF;
            lock     <= 8'hFF;
            lat_lo   <= NVP_FUSE_LOW_DEF;
            lat_hi   <= NVP_FUSE_HIGH_DEF;

            dout     <= 8'h00;
            trim     <= 8'h00;
            // edge history rests at the idle pin levels
            clk_q    <= 1'b0;
            wr_q     <= 1'b1;
            oe_q     <= 1'b1;
            erase_f  <= 1'b0;
            erase_e  <= 1'b0;
            start    <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            busy_cnt <= next_busy_cnt;
            cmd      <= next_cmd;
            addr_lo  <= next_addr_lo;
            addr_hi  <= next_addr_hi;
            dat_lo   <= next_dat_lo;

            fuse_lo  <= next_fuse_lo;
            fuse_hi  <= next_fuse_hi;
            fuse_ext <= next_fuse_ext;
            lock     <= next_lock;
            lat_lo   <= next_lat_lo;
            lat_hi   <= next_lat_hi;

            dout     <= next_dout;
            trim     <= next_trim;

            clk_q    <= i_pins.prog_clock_in;
            wr_q     <= i_pins.wr_n;
            oe_q     <= i_pins.oe_n;
            erase_f  <= next_erase_f;
            erase_e  <= next_erase_e;
            start    <= next_start;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_data         = dout;
    assign o_data_oe      = i_prog_mode & ~i_pins.oe_n;
    assign o_ready_busy_n = ready;

    assign o_addr_low     = addr_lo;
    assign o_addr_high    = addr_hi;
    assign o_word_in_page_index = addr_lo[NVP_FLASH_WORD_BITS-1:0];
    // page bit 9 stays zero: no extended address byte
    assign o_page_index   = {1'b0, addr_hi, addr_lo[NVP_FLASH_WORD_BITS]};
    assign o_eeprom_byte_addr = addr_lo[NVP_EE_BYTE_BITS-1:0];

    assign o_erase_flash  = erase_f;
    assign o_erase_eeprom = erase_e;

    assign o_cmd          = cmd;
    assign o_cmd_start    = start;
    assign o_rc_osc_trim_reg = trim;
    // eeprom-keep from live fuse, rest from latch
    assign o_cfg.eeprom_keep_fuse        = fuse_hi[NVP_HI_EEKEEP];
    assign o_cfg.boot_size_sel           = lat_hi[NVP_HI_BOOT_HI:NVP_HI_BOOT_LO];
    assign o_cfg.reset_vector_sel        = lat_hi[NVP_HI_RSTVEC];
    assign o_cfg.clk_prescale_eight_fuse = lat_lo[NVP_LO_PRESCALE];
    assign o_cfg.clock_out_fuse          = lat_lo[NVP_LO_CLKOUT];
    assign o_cfg.startup_time_sel        = lat_lo[NVP_LO_SUT_HI:NVP_LO_SUT_LO];
    assign o_cfg.clock_source_sel        = lat_lo[NVP_LO_CKSEL_MSB:0];

endmodule : nvp_core

/* hdl/nvp_pkg.sv */
// constants, field layouts and types of the fuse and parallel-programming block
// assumes one clock at 100 MHz and an active-low asynchronous reset
//
// Overview of operation
// - high fuse bit 3 keeps eeprom through erase
// - high bits 2:1 boot size, bit 0 vector
// - low bits 3:0 clock source, bit 7 prescale
// - low bits 5:4 select oscillator start-up time
// - low bit 6 programmed drives clock out
// - serial-allow fuse frozen in serial programming
// - chip erase leaves every fuse unchanged
// - first lock bit programmed freezes fuses
// - fuses captured on programming entry, deferred
// - eeprom-keep fuse acts immediately when programmed
// - normal mode captures fuses at power-up
// - three-byte identity readable regardless of lock
// - user signature pages survive chip erase
// - calibration byte copied to trim each clock after reset, which loads zero
// - flash pages of 128 words
// - eeprom pages of 8 bytes
// - ready_busy_n low while operation runs
// - data bus driven only while oe low
// - clock pulse performs action-select action
// - strobes run the last loaded command
// - action 00 addr, 01 data, 10 cmd, 11 idle
// - command 0x80 plus write strobe erases chip
// - programmed fuse reads zero
package nvp_pkg;

    // ****************************************
    // fuse layouts and defaults
    // ****************************************
    localparam logic [7:0] NVP_FUSE_LOW_DEF  = 8'h62;   // 0110_0010
    localparam logic [7:0] NVP_FUSE_HIGH_DEF = 8'h99;   // 1001_1001
    localparam logic [7:0] NVP_FUSE_EXT_DEF  = 8'hFE;
    localparam int         NVP_HI_EEKEEP     = 3;
    localparam int         NVP_HI_BOOT_HI    = 2;
    localparam int         NVP_HI_BOOT_LO    = 1;
    localparam int         NVP_HI_RSTVEC     = 0;
    localparam int         NVP_HI_SERIAL     = 5;
    localparam int         NVP_LO_PRESCALE   = 7;
    localparam int         NVP_LO_CLKOUT     = 6;
    localparam int         NVP_LO_SUT_HI     = 5;
    localparam int         NVP_LO_SUT_LO     = 4;
    localparam int         NVP_LO_CKSEL_MSB  = 3;
    localparam int         NVP_LOCK_FIRST    = 0;

    // ****************************************
    // page geometry
    // ****************************************
    localparam int NVP_FLASH_WORD_BITS = 7;   // 128 words
    localparam int NVP_EE_BYTE_BITS    = 3;   // 8 bytes

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] NVP_CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] NVP_CMD_WR_FUSE    = 8'h40;
    localparam logic [7:0] NVP_CMD_WR_LOCK    = 8'h20;
    localparam logic [7:0] NVP_CMD_WR_FLASH   = 8'h10;
    localparam logic [7:0] NVP_CMD_WR_EEPROM  = 8'h11;
    localparam logic [7:0] NVP_CMD_WR_USIG    = 8'h12;
    localparam logic [7:0] NVP_CMD_ER_USIG    = 8'h84;
    localparam logic [7:0] NVP_CMD_ER_EEPROM  = 8'h82;
    localparam logic [7:0] NVP_CMD_RD_SIG     = 8'h08;
    localparam logic [7:0] NVP_CMD_RD_FUSE    = 8'h04;

    // ****************************************
    // timing
    // ****************************************
    localparam int NVP_CLK_MHZ      = 100;
    localparam int NVP_BUSY_NS      = 1000;   // operation time
    localparam int NVP_BUSY_CYCLES  = (NVP_BUSY_NS * NVP_CLK_MHZ) / 1000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        NVP_ACT_ADDR = 2'b00,
        NVP_ACT_DATA = 2'b01,
        NVP_ACT_CMD  = 2'b10,
        NVP_ACT_IDLE = 2'b11
    } nvp_action_t;

    typedef enum logic [0:0] {
        NVP_ST_READY = 1'b0,
        NVP_ST_BUSY  = 1'b1
    } nvp_state_t;

    // decoded fuse settings seen by the rest of the chip
    typedef struct packed {
        logic       eeprom_keep_fuse;
        logic [1:0] boot_size_sel;
        logic       reset_vector_sel;
        logic       clk_prescale_eight_fuse;
        logic       clock_out_fuse;
        logic [1:0] startup_time_sel;
        logic [3:0] clock_source_sel;
    } nvp_fuse_cfg_t;

    // programming pin group from the programmer
    typedef struct packed {
        logic       prog_clock_in;
        logic [1:0] action_sel;
        logic       byte_select_low;
        logic       byte_select_high;
        logic       wr_n;
        logic       oe_n;
        logic       page_latch_strobe;
    } nvp_pins_t;

endpackage : nvp_pkg

/* test/nvp_core_properties.sv */
// assertions for the fuse and parallel-programming block
// assumes a bind onto nvp_core and a single clock domain
module nvp_core_properties
    import nvp_pkg::*;
#(
    parameter int         BUSY_CYCLES = NVP_BUSY_CYCLES,   // length of one operation
    parameter logic [7:0] CAL_BYTE    = 8'h80              // expected trim value
)(
    // clock, reset and mode inputs
    input wire logic                   i_clk, i_rst_n, i_power_up, i_prog_entry, i_prog_mode,
    // programmer side
    input wire nvp_pkg::nvp_pins_t     i_pins,
    input wire logic [7:0]             i_data, o_addr_low, o_cmd, o_rc_osc_trim_reg,
    // device outputs
    input wire logic                   o_data_oe, o_ready_busy_n, o_erase_flash, o_erase_eeprom, o_cmd_start,
    input wire logic [6:0]             o_word_in_page_index,
    input wire logic [2:0]             o_eeprom_byte_addr,
    input wire nvp_pkg::nvp_fuse_cfg_t o_cfg
);
    // ****************************************
    // busy length counter
    // ****************************************
    int unsigned busy_cnt;        // low cycles seen so far
    int unsigned next_busy_cnt;   // next count
    always_comb next_busy_cnt = o_ready_busy_n ? 0 : busy_cnt + 1;
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n) busy_cnt <= 0;
        else busy_cnt <= next_busy_cnt;

    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    busy_len_a: assert property ($rose(o_ready_busy_n) |-> busy_cnt == BUSY_CYCLES)
        else $error("busy period has the wrong length");
    erase_busy_a: assert property ($rose(o_erase_flash) |-> !o_ready_busy_n ##1 !o_erase_flash)
        else $error("erase pulse malformed");
    eeprom_keep_a: assert property (o_erase_eeprom |-> o_erase_flash && o_cfg.eeprom_keep_fuse)
        else $error("eeprom erased though kept");
    data_drive_a: assert property (o_data_oe == (i_prog_mode && !i_pins.oe_n))
        else $error("data drive mismatch");
    busy_hold_a: assert property (!o_ready_busy_n && !$past(o_ready_busy_n)
        |-> $stable(o_cmd) && $stable(o_addr_low))
        else $error("command or address changed while busy");
    fuse_hold_a: assert property (!$past(i_prog_entry) && !$past(i_power_up)
        && !$past(i_prog_entry, 2) && !$past(i_power_up, 2) |-> $stable(o_cfg[10:0]))
        else $error("latched fuses moved");
    cmd_load_a: assert property (i_prog_mode && o_ready_busy_n && i_pins.action_sel == NVP_ACT_CMD
        && i_pins.prog_clock_in && !$past(i_pins.prog_clock_in) |=> o_cmd == $past(i_data))
        else $error("command byte not loaded on clock pulse");
    start_once_a: assert property (o_cmd_start |=> !o_cmd_start)
        else $error("command start longer than one cycle");
    addr_map_a: assert property (o_word_in_page_index == o_addr_low[6:0]
        && o_eeprom_byte_addr == o_addr_low[2:0])
        else $error("page word or eeprom byte index wrong");
    trim_a: assert property ($past(i_rst_n) |-> o_rc_osc_trim_reg == CAL_BYTE)
        else $error("trim not calibration");
    erase_both_c: cover property (o_erase_flash && o_erase_eeprom);
    erase_keep_c: cover property (o_erase_flash && !o_erase_eeprom);
    read_drive_c: cover property (o_data_oe);
endmodule : nvp_core_properties

bind nvp_core nvp_core_properties #(.BUSY_CYCLES(BUSY_CYCLES), .CAL_BYTE(CAL_BYTE)) nvp_core_properties_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_up(i_power_up), .i_prog_entry(i_prog_entry),
    .i_prog_mode(i_prog_mode), .i_pins(i_pins), .i_data(i_data), .o_addr_low(o_addr_low), .o_cmd(o_cmd),
    .o_rc_osc_trim_reg(o_rc_osc_trim_reg), .o_data_oe(o_data_oe), .o_ready_busy_n(o_ready_busy_n),
    .o_erase_flash(o_erase_flash), .o_erase_eeprom(o_erase_eeprom), .o_cmd_start(o_cmd_start),
    .o_word_in_page_index(o_word_in_page_index), .o_eeprom_byte_addr(o_eeprom_byte_addr), .o_cfg(o_cfg));

/* test/nvp_prog_model.sv */
// model of the external parallel programmer driving the programming pins
// assumes the bench resolves the shared data bus from both drivers
module nvp_prog_model
    import nvp_pkg::*;
(
    // clock and resolved bus
    input  wire logic          i_clk,
    input  wire logic [7:0]    i_bus,
    // pins toward the device
    output nvp_pkg::nvp_pins_t o_pins,
    output logic [7:0]         o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pins: no action, strobes released
    initial
    begin
        o_pins = '{1'b0, 2'b11, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        o_data = 8'h00;
    end
    // set action, select and data, then one positive clock pulse
    task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] val);
        @(posedge i_clk);
        o_pins.action_sel <= act;
        {o_pins.byte_select_high, o_pins.byte_select_low} <= bs;
        o_data <= val;
        @(posedge i_clk);
        o_pins.prog_clock_in <= 1'b1;
        @(posedge i_clk);
        o_pins.prog_clock_in <= 1'b0;
        o_pins.action_sel <= 2'b11;
        o_data <= ~val;   // released bus shows the inverse
        @(posedge i_clk);
    endtask : load
    // negative write pulse starts the loaded command
    task automatic strobe_wr(input logic [1:0] bs);
        @(posedge i_clk);
        {o_pins.byte_select_high, o_pins.byte_select_low} <= bs;
        o_pins.wr_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_pins.wr_n <= 1'b1;
    endtask : strobe_wr
    // output-enable pulse; the bus is sampled while the device drives it
    task automatic strobe_oe(input logic [1:0] bs, output logic [7:0] rd);
        @(posedge i_clk);
        {o_pins.byte_select_high, o_pins.byte_select_low} <= bs;
        o_pins.oe_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        rd = i_bus;
        o_pins.oe_n <= 1'b1;
    endtask : strobe_oe
endmodule : nvp_prog_model

/* test/test_nvp_core.sv */
// self-checking bench for the fuse and parallel-programming block
// assumes nvp_core, the programmer model and the bound checker
module test_nvp_core
    import nvp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY = 3;   // shortened operation time
    logic          i_clk, i_rst_n, i_power_up, i_prog_entry, i_prog_mode, i_serial_mode;
    nvp_pins_t     pins;
    logic [7:0]    prog_data, bus, o_data, o_addr_low, o_addr_high, o_cmd, o_trim, v;
    logic          o_data_oe, o_ready_busy_n, o_erase_flash, o_erase_eeprom, o_cmd_start;
    logic [6:0]    o_word;
    logic [9:0]    o_page;
    logic [2:0]    o_ee;
    nvp_fuse_cfg_t o_cfg;
    int            num_errors, cmp_count, n_ef, n_ee;
    assign bus = o_data_oe ? o_data : prog_data;

    nvp_core #(.BUSY_CYCLES(BUSY)) nvp_core_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_up(i_power_up), .i_prog_entry(i_prog_entry),
        .i_prog_mode(i_prog_mode), .i_serial_mode(i_serial_mode), .i_pins(pins), .i_data(bus),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_ready_busy_n(o_ready_busy_n), .o_addr_low(o_addr_low),
        .o_addr_high(o_addr_high), .o_word_in_page_index(o_word), .o_page_index(o_page),
        .o_eeprom_byte_addr(o_ee), .o_erase_flash(o_erase_flash), .o_erase_eeprom(o_erase_eeprom),
        .o_cmd(o_cmd), .o_cmd_start(o_cmd_start), .o_cfg(o_cfg), .o_rc_osc_trim_reg(o_trim));
    nvp_prog_model nvp_prog_model_i (.i_clk(i_clk), .i_bus(bus), .o_pins(pins), .o_data(prog_data));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // count erase pulses
    always @(posedge i_clk)
    begin
        if (o_erase_flash === 1'b1) n_ef++;
        if (o_erase_eeprom === 1'b1) n_ee++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_ready();
        int n;
        for (n = 0; n < 50 && o_ready_busy_n !== 1'b1; n++) @(posedge i_clk);
        check("ready wait", 10'h001, {9'h000, o_ready_busy_n});
        if (n == 50) tally_and_finish();
    endtask : wait_ready
    task automatic cmd(input logic [7:0] c);
        nvp_prog_model_i.load(NVP_ACT_CMD, 2'b00, c);
    endtask : cmd
    task automatic run(input logic [7:0] c, input logic [7:0] d, input logic [1:0] bs);
        cmd(c);
        nvp_prog_model_i.load(NVP_ACT_DATA, 2'b00, d);
        nvp_prog_model_i.strobe_wr(bs);
        wait_ready();
    endtask : run
    task automatic rd_fuse(input logic [1:0] bs, input logic [7:0] exp);
        cmd(NVP_CMD_RD_FUSE);
        nvp_prog_model_i.strobe_oe(bs, v);
        check("fuse read", exp, v);
    endtask : rd_fuse
    task automatic latch(input bit entry);
        @(posedge i_clk);
        if (entry) i_prog_entry <= 1'b1;
        else i_power_up <= 1'b1;
        @(posedge i_clk);
        i_prog_entry <= 1'b0;
        i_power_up <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : latch

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        check("fuse cfg", 10'h162, o_cfg[9:0]);
        check("keep fuse", 10'h001, o_cfg.eeprom_keep_fuse);
        check("trim", 10'h080, o_trim);
        rd_fuse(2'b00, 8'h62);
        rd_fuse(2'b11, 8'h99);
        rd_fuse(2'b10, 8'hFE);
    endtask : t_defaults
    task automatic t_addr();
        nvp_prog_model_i.load(NVP_ACT_ADDR, 2'b00, 8'hAB);
        nvp_prog_model_i.load(NVP_ACT_ADDR, 2'b01, 8'h05);
        check("word index", 10'h02B, o_word);
        check("page index", 10'h00B, {1'b0, o_page[8:0]});
        check("eeprom byte", 10'h003, o_ee);
    endtask : t_addr
    task automatic t_erase(input int ee_inc);
        int ef0;
        int ee0;
        ef0 = n_ef;
        ee0 = n_ee;
        cmd(NVP_CMD_CHIP_ERASE);
        nvp_prog_model_i.strobe_wr(2'b00);
        check("busy low", 10'h000, o_ready_busy_n);
        wait_ready();
        check("flash erase", 10'(ef0 + 1), 10'(n_ef));
        check("eeprom erase", 10'(ee0 + ee_inc), 10'(n_ee));
    endtask : t_erase
    task automatic t_defer();
        run(NVP_CMD_WR_FUSE, 8'h22, 2'b00);
        check("clock out held", 10'h001, o_cfg.clock_out_fuse);
        rd_fuse(2'b00, 8'h22);
        latch(1'b1);
        check("clock out on", 10'h000, o_cfg.clock_out_fuse);
        run(NVP_CMD_WR_FUSE, 8'h62, 2'b00);
        latch(1'b0);
        check("clock out off", 10'h001, o_cfg.clock_out_fuse);
    endtask : t_defer
    task automatic t_keep();
        run(NVP_CMD_WR_FUSE, 8'h91, 2'b01);
        check("keep now", 10'h000, o_cfg.eeprom_keep_fuse);
        t_erase(0);
        rd_fuse(2'b11, 8'h91);
        i_serial_mode <= 1'b1;
        run(NVP_CMD_WR_FUSE, 8'hB1, 2'b01);
        rd_fuse(2'b11, 8'h91);
        i_serial_mode <= 1'b0;
    endtask : t_keep
    task automatic t_lock();
        run(NVP_CMD_WR_LOCK, 8'hFE, 2'b00);
        rd_fuse(2'b01, 8'hFE);
        run(NVP_CMD_WR_FUSE, 8'h00, 2'b00);
        rd_fuse(2'b00, 8'h62);
        cmd(NVP_CMD_RD_SIG);
        for (int i = 0; i < 4; i++)
        begin
            nvp_prog_model_i.load(NVP_ACT_ADDR, 2'b00, 8'(i % 3));
            nvp_prog_model_i.strobe_oe({1'b0, i == 3}, v);
            check("signature", i == 3 ? 10'h080 : i == 1 ? 10'h03C : i == 2 ? 10'h001 : 10'h05A, v);
        end
    endtask : t_lock

    initial
    begin
        i_rst_n = 1'b0;
        i_power_up = 1'b0;
        i_prog_entry = 1'b0;
        i_prog_mode = 1'b1;
        i_serial_mode = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        latch(1'b1);
        repeat (5000) @(posedge i_clk);
        t_defaults();
        t_addr();
        t_erase(1);
        t_defer();
        t_keep();
        t_lock();
        tally_and_finish();
    end
    // cut a hang short
    initial
    begin
        repeat (100000) @(posedge i_clk);
        num_errors++;
        $display("ERROR run time expected end seen hang");
        tally_and_finish();
    end
endmodule : test_nvp_core
